/* common/ctg_pkg.sv */
/*
 contents: constants, types and decode helpers of the carrier trip/guard
 receiver logic.
 surroundings: a 200 MHz system clock; switch fields reached over an
 Avalon-MM register slave.
*/
`default_nettype none
package ctg_pkg;
	// ********************
	// timing
	// ********************
	localparam int CLK_FREQ_KHZ = 200000;
	localparam int TICK_TIME_MS = 1;
	localparam int TICK_CYCLES  = CLK_FREQ_KHZ * TICK_TIME_MS;
	localparam int TMR_W        = 11;
	localparam logic [TMR_W-1:0] PRETRIP_STEP_MS = 11'h002;
	localparam logic [TMR_W-1:0] HOLD_A_MS       = 11'h00a;
	localparam logic [TMR_W-1:0] HOLD_B_MS       = 11'h032;
	localparam logic [TMR_W-1:0] HOLD_C_MS       = 11'h064;
	localparam logic [TMR_W-1:0] UNBLOCK_A_MS    = 11'h096;
	localparam logic [TMR_W-1:0] UNBLOCK_B_MS    = 11'h12c;
	localparam logic [TMR_W-1:0] UNBLOCK_C_MS    = 11'h1f4;
	localparam logic [TMR_W-1:0] LL_A_MS         = 11'h032;
	localparam logic [TMR_W-1:0] LL_B_MS         = 11'h04b;
	localparam logic [TMR_W-1:0] LL_C_MS         = 11'h064;
	localparam logic [TMR_W-1:0] GUARD_FIRST_MS  = 11'h078;
	localparam logic [TMR_W-1:0] OVERRIDE_MS     = 11'h3e8;
	localparam logic [TMR_W-1:0] OVERRIDE_LIM    = OVERRIDE_MS + 11'h001;
	// ********************
	// register map
	// ********************
	localparam int AV_ADDR_W = 4;
	localparam logic [AV_ADDR_W-1:0] CFG_OFS    = 4'h0;
	localparam logic [AV_ADDR_W-1:0] STATUS_OFS = 4'h4;
	localparam logic [31:0] CFG_RST   = 32'h0000_0000;
	localparam logic [31:0] CFG_WMASK = 32'h01ff_ffff;
	// ********************
	// types
	// ********************
	typedef struct packed {
		logic [6:0] rsvd;
		logic       three_freq;
		logic [1:0] lowlevel_dly;
		logic [5:0] bank3_spare;
		logic [2:0] bank2_spare;
		logic [1:0] guard_first_sel;
		logic       noise_block_en;
		logic [1:0] unblock_sel;
		logic [1:0] guardhold_sel;
		logic [1:0] triphold_sel;
		logic [3:0] pretrip_sel;
	} cfg_type;
	typedef struct packed {
		logic trip;
		logic guard;
		logic lowlevel;
		logic noise;
	} chan_type;
	typedef enum logic [1:0] {GF_OFF, GF_NO_OVR, GF_OVR} gf_mode_type;
	// ********************
	// decoders
	// ********************
	function automatic logic [TMR_W-1:0] hold_ms(input logic [1:0] sel);
		unique case (sel)
			2'h0: hold_ms = 11'h000;
			2'h1: hold_ms = HOLD_A_MS;
			2'h2: hold_ms = HOLD_B_MS;
			2'h3: hold_ms = HOLD_C_MS;
		endcase
	endfunction
	function automatic logic [TMR_W-1:0] unblock_ms(input logic [1:0] sel);
		unique case (sel)
			2'h0: unblock_ms = 11'h000;
			2'h1: unblock_ms = UNBLOCK_A_MS;
			2'h2: unblock_ms = UNBLOCK_B_MS;
			2'h3: unblock_ms = UNBLOCK_C_MS;
		endcase
	endfunction
	function automatic logic [TMR_W-1:0] ll_ms(input logic [1:0] sel);
		unique case (sel)
			2'h0: ll_ms = 11'h000;
			2'h1: ll_ms = LL_A_MS;
			2'h2: ll_ms = LL_B_MS;
			2'h3: ll_ms = LL_C_MS;
		endcase
	endfunction
	function automatic gf_mode_type gf_decode(input logic [1:0] sel);
		unique case (sel)
			2'h1:    gf_decode = GF_NO_OVR;
			2'h2:    gf_decode = GF_OVR;
			default: gf_decode = GF_OFF;
		endcase
	endfunction
endpackage
`default_nettype wire

/* hdl/ms_qualify.sv */
/*
 contents: millisecond persistence qualifier; in stretch form it extends
 a level after it ends.
 surroundings: one-cycle tick pulse per millisecond, synchronous reset.
*/
`timescale 1ns/1ps
`default_nettype none
module ms_qualify #(
	parameter int W       = 11,
	parameter bit STRETCH = 1'b0
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         rst,
	// timing
	input  wire logic         tick,
	input  wire logic [W-1:0] limit,
	// signal
	input  wire logic         level,
	output var  logic         qualified
);
	logic [W-1:0] cnt_ff;
	logic [W-1:0] nxt_cnt;
	logic         qualified_ff;

	if (W < 1) begin : g_chk
		$error("ms_qualify: W must be at least 1");
	end

	// ********************
	// persistence counter
	// ********************
	always_comb
	begin
		nxt_cnt = cnt_ff;
		if (!level)
			nxt_cnt = '0;
		else if (tick && (cnt_ff < limit))
			nxt_cnt = cnt_ff + 1'b1;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			cnt_ff <= STRETCH ? '1 : '0;
		else
			cnt_ff <= nxt_cnt;
	end

	// stretch form sees the inverted level and inverts the result
	always_ff @(posedge clk)
	begin
		if (rst)
			qualified_ff <= 1'b0;
		else
			qualified_ff <= STRETCH ^ (level && (nxt_cnt >= limit));
	end

	assign qualified = qualified_ff;
endmodule // ms_qualify
`default_nettype wire

/* hdl/carrier_trip_guard_logic.sv */
/*
 contents: receiver trip/guard logic with switch-selected timers and an
 Avalon-MM slave holding the switch fields and a status word.
 surroundings: discriminator conditions synchronous to clk; relay drivers
 take the trip, guard and low-level outputs.
*/
`timescale 1ns/1ps
`default_nettype none
module carrier_trip_guard_logic #(
	parameter int TICK_CYCLES = ctg_pkg::TICK_CYCLES
) (
	// clock and reset
	input  wire logic                           clk,
	input  wire logic                           rst,
	// register bus
	input  wire logic [ctg_pkg::AV_ADDR_W-1:0] av_address,
	input  wire logic                           av_read,
	input  wire logic                           av_write,
	input  wire logic [31:0]                    av_writedata,
	input  wire logic [3:0]                     av_byteenable,
	output var  logic [31:0]                    av_readdata,
	output var  logic                           av_waitrequest,
	// channel conditions
	input  wire ctg_pkg::chan_type              chan,
	// relay outputs
	output var  logic                           trip_out,
	output var  logic                           guard_out,
	output var  logic                           lowlevel_out
);
	localparam int TW = $clog2(TICK_CYCLES + 1);

	if (TICK_CYCLES < 1) begin : g_chk
		$error("carrier_trip_guard_logic: TICK_CYCLES must be at least 1");
	end

	logic [31:0]                cfg_ff;
	logic [31:0]                nxt_cfg;
	ctg_pkg::cfg_type           cfg;
	logic [31:0]                readdata_ff;
	logic                       waitrequest_ff;
	logic [TW-1:0]              tick_cnt_ff;
	logic                       tick_ff;
	logic [ctg_pkg::TMR_W-1:0]  pretrip_lim;
	logic [ctg_pkg::TMR_W-1:0]  triphold_lim;
	logic [ctg_pkg::TMR_W-1:0]  guardhold_lim;
	logic [ctg_pkg::TMR_W-1:0]  unblock_lim;
	logic [ctg_pkg::TMR_W-1:0]  ll_lim;
	ctg_pkg::gf_mode_type       gf_mode;
	logic                       loss_raw;
	logic                       loss_q;
	logic                       loss_d_ff;
	logic                       loss_rise;
	logic                       unblock_open_ff;
	logic [ctg_pkg::TMR_W-1:0]  unblock_cnt_ff;
	logic                       unblock_start;
	logic                       noise_stop;
	logic                       trip_cond;
	logic                       pretrip_q;
	logic                       guard120_q;
	logic                       trip1000_q;
	logic                       armed_ff;
	logic                       loss_seen_ff;
	logic                       permit;
	logic                       trip_act;
	logic [31:0]                status;

	// ********************
	// register slave
	// ********************
	assign cfg = ctg_pkg::cfg_type'(cfg_ff);

	always_comb
	begin
		nxt_cfg = cfg_ff;
		for (int i = 0; i < 4; i++)
			if (av_byteenable[i])
				nxt_cfg[8*i +: 8] = av_writedata[8*i +: 8];
		nxt_cfg = nxt_cfg & ctg_pkg::CFG_WMASK;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			cfg_ff <= ctg_pkg::CFG_RST;
		else if (av_write && !waitrequest_ff && av_address == ctg_pkg::CFG_OFS)
			cfg_ff <= nxt_cfg;
	end

	assign status = {22'h0, loss_seen_ff, armed_ff, unblock_open_ff, loss_q,
		lowlevel_out, guard_out, trip_out, chan.trip, chan.guard, chan.noise};

	// accept in one cycle, complete in the next
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			waitrequest_ff <= 1'b1;
			readdata_ff    <= 32'h0000_0000;
		end
		else if ((av_read || av_write) && waitrequest_ff)
		begin
			waitrequest_ff <= 1'b0;
			if (av_read && av_address == ctg_pkg::CFG_OFS)
				readdata_ff <= cfg_ff;
			else if (av_read && av_address == ctg_pkg::STATUS_OFS)
				readdata_ff <= status;
			else
				readdata_ff <= 32'h0000_0000;
		end
		else
			waitrequest_ff <= 1'b1;
	end

	assign av_readdata    = readdata_ff;
	assign av_waitrequest = waitrequest_ff;

	// ********************
	// millisecond tick
	// ********************
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			tick_cnt_ff <= '0;
			tick_ff     <= 1'b0;
		end
		else if (tick_cnt_ff == TW'(TICK_CYCLES - 1))
		begin
			tick_cnt_ff <= '0;
			tick_ff     <= 1'b1;
		end
		else
		begin
			tick_cnt_ff <= tick_cnt_ff + 1'b1;
			tick_ff     <= 1'b0;
		end
	end

	// ********************
	// switch decode
	// ********************
	// spare bank bits and the frequency mode bit steer nothing
	assign pretrip_lim   = ctg_pkg::TMR_W'(cfg.pretrip_sel) * ctg_pkg::PRETRIP_STEP_MS;
	assign triphold_lim  = ctg_pkg::hold_ms(cfg.triphold_sel);
	assign guardhold_lim = ctg_pkg::hold_ms(cfg.guardhold_sel);
	assign unblock_lim   = ctg_pkg::unblock_ms(cfg.unblock_sel);
	assign ll_lim        = ctg_pkg::ll_ms(cfg.lowlevel_dly);
	assign gf_mode       = ctg_pkg::gf_decode(cfg.guard_first_sel);

	// ********************
	// loss of channel and unblock window
	// ********************
	assign loss_raw = chan.lowlevel && !chan.guard;

	ms_qualify #(.W(ctg_pkg::TMR_W), .STRETCH(1'b0)) u_loss (
		.clk       (clk),
		.rst       (rst),
		.tick      (tick_ff),
		.limit     (ll_lim),
		.level     (loss_raw),
		.qualified (loss_q)
	);

	always_ff @(posedge clk)
	begin
		if (rst)
			loss_d_ff <= 1'b0;
		else
			loss_d_ff <= loss_q;
	end

	assign loss_rise     = loss_q && !loss_d_ff;
	assign noise_stop    = cfg.noise_block_en && chan.noise;
	assign unblock_start = loss_rise && (unblock_lim != '0) && !noise_stop;

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			unblock_open_ff <= 1'b0;
			unblock_cnt_ff  <= '0;
		end
		else if (unblock_start)
		begin
			unblock_open_ff <= 1'b1;
			unblock_cnt_ff  <= '0;
		end
		else if (unblock_open_ff)
		begin
			if (noise_stop || !loss_q)
				unblock_open_ff <= 1'b0;
			else if (tick_ff && (unblock_cnt_ff + 1'b1 >= unblock_lim))
				unblock_open_ff <= 1'b0;
			if (tick_ff)
				unblock_cnt_ff <= unblock_cnt_ff + 1'b1;
		end
	end

	// ********************
	// trip path
	// ********************
	assign trip_cond = chan.trip || unblock_open_ff;

	ms_qualify #(.W(ctg_pkg::TMR_W), .STRETCH(1'b0)) u_pretrip (
		.clk       (clk),
		.rst       (rst),
		.tick      (tick_ff),
		.limit     (pretrip_lim),
		.level     (trip_cond),
		.qualified (pretrip_q)
	);

	ms_qualify #(.W(ctg_pkg::TMR_W), .STRETCH(1'b0)) u_guard120 (
		.clk       (clk),
		.rst       (rst),
		.tick      (tick_ff),
		.limit     (ctg_pkg::GUARD_FIRST_MS),
		.level     (chan.guard),
		.qualified (guard120_q)
	);

	ms_qualify #(.W(ctg_pkg::TMR_W), .STRETCH(1'b0)) u_trip1000 (
		.clk       (clk),
		.rst       (rst),
		.tick      (tick_ff),
		.limit     (ctg_pkg::OVERRIDE_LIM),
		.level     (chan.trip),
		.qualified (trip1000_q)
	);

	// guard arming: set wins over the clear in both flags
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			armed_ff     <= 1'b0;
			loss_seen_ff <= 1'b0;
		end
		else
		begin
			armed_ff     <= guard120_q || (armed_ff && !loss_rise);
			loss_seen_ff <= loss_rise || (loss_seen_ff && !guard120_q);
		end
	end

	always_comb
	begin
		unique case (gf_mode)
			ctg_pkg::GF_OFF:    permit = 1'b1;
			ctg_pkg::GF_NO_OVR: permit = armed_ff;
			ctg_pkg::GF_OVR:    permit = armed_ff || trip1000_q || loss_seen_ff;
			default:            permit = 1'b1;
		endcase
	end

	assign trip_act = pretrip_q && permit;

	// ********************
	// output stretchers and low-level alarm delay
	// ********************
	ms_qualify #(.W(ctg_pkg::TMR_W), .STRETCH(1'b1)) u_trip_hold (
		.clk       (clk),
		.rst       (rst),
		.tick      (tick_ff),
		.limit     (triphold_lim),
		.level     (!trip_act),
		.qualified (trip_out)
	);

	ms_qualify #(.W(ctg_pkg::TMR_W), .STRETCH(1'b1)) u_guard_hold (
		.clk       (clk),
		.rst       (rst),
		.tick      (tick_ff),
		.limit     (guardhold_lim),
		.level     (!chan.guard),
		.qualified (guard_out)
	);

	ms_qualify #(.W(ctg_pkg::TMR_W), .STRETCH(1'b0)) u_ll_alarm (
		.clk       (clk),
		.rst       (rst),
		.tick      (tick_ff),
		.limit     (ll_lim),
		.level     (chan.lowlevel),
		.qualified (lowlevel_out)
	);

	// ********************
	// assertions
	// ********************
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	pretrip_delay_a: assert property (pretrip_q |-> $past(trip_cond))
		else $error("pretrip qualified without trip condition");
	pretrip_decode_a: assert property (cfg.pretrip_sel == 4'hf |-> pretrip_lim == 11'h01e)
		else $error("pretrip all closed is not 30 ms");
	trip_hold_off_a: assert property ((triphold_lim == '0 && !trip_act) |=> !trip_out)
		else $error("trip output held with hold disabled");
	trip_hold_on_a: assert property (($fell(trip_act) && triphold_lim != '0) |=> trip_out)
		else $error("trip output not stretched");
	guard_hold_off_a: assert property ((guardhold_lim == '0 && !chan.guard) |=> !guard_out)
		else $error("guard output held with hold disabled");
	unblock_start_a: assert property ($rose(unblock_open_ff) |->
		$past(loss_rise) && $past(unblock_lim) != '0)
		else $error("unblock window opened without loss of channel");
	noise_block_a: assert property (noise_stop |=> !unblock_open_ff)
		else $error("noise did not block unblock window");
	guard_first_a: assert property ((gf_mode == ctg_pkg::GF_NO_OVR && trip_act) |-> armed_ff)
		else $error("trip without prior guard");
	gf_decode_a: assert property (cfg.guard_first_sel == 2'h3 |-> gf_mode == ctg_pkg::GF_OFF)
		else $error("illegal guard-first code not off");
	ll_alarm_a: assert property (lowlevel_out |-> $past(chan.lowlevel))
		else $error("low-level alarm without low level");
	reset_clear_a: assert property (@(posedge clk) disable iff (1'b0)
		rst |=> !trip_out && !guard_out && !lowlevel_out)
		else $error("outputs active after reset");

	unblock_open_c: cover property ($rose(unblock_open_ff));
	override_trip_c: cover property (gf_mode == ctg_pkg::GF_OVR && trip_act && !armed_ff);
	trip_hold_c: cover property ($fell(trip_act) && triphold_lim != '0 ##1 trip_out);
endmodule // carrier_trip_guard_logic
`default_nettype wire

/* testbench/chan_source.sv */
/*
 contents: discriminator stand-in that presents channel conditions to
 the receiver logic one clock after the bench commands them.
 surroundings: same clock and synchronous reset as the receiver logic.
*/
`timescale 1ns/1ps
`default_nettype none
module chan_source (
	// clock and reset
	input  wire logic              clk,
	input  wire logic              rst,
	// commanded and presented conditions
	input  wire ctg_pkg::chan_type want,
	output var  ctg_pkg::chan_type chan
);
	// ********************
	// registered levels, quiet in reset
	// ********************
	always_ff @(posedge clk)
	begin
		chan <= rst ? '0 : want;
	end
endmodule // chan_source
`default_nettype wire

/* testbench/tb_top.sv */
/*
 contents: self-checking bench of the carrier trip/guard logic.
 surroundings: shortened millisecond tick; chan_source drives the channel.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	localparam int T = 10;
	logic clk, rst, av_read, av_write, av_waitrequest;
	logic [3:0] av_address, av_byteenable;
	logic [31:0] av_writedata, av_readdata, q;
	logic trip_out, guard_out, lowlevel_out;
	ctg_pkg::chan_type want, chan;
	wire [2:0] outs;
	int failures, checks, n;
	int hv[4] = '{0, 10, 50, 100};
	int lv[4] = '{0, 50, 75, 100};
	int uv[4] = '{0, 150, 300, 500};
	assign outs = {trip_out, guard_out, lowlevel_out};
	chan_source u_src (.clk(clk), .rst(rst), .want(want), .chan(chan));
	carrier_trip_guard_logic #(.TICK_CYCLES(T)) u_dut (
		.clk(clk), .rst(rst), .av_address(av_address), .av_read(av_read),
		.av_write(av_write), .av_writedata(av_writedata),
		.av_byteenable(av_byteenable), .av_readdata(av_readdata),
		.av_waitrequest(av_waitrequest), .chan(chan), .trip_out(trip_out),
		.guard_out(guard_out), .lowlevel_out(lowlevel_out));
	// ********************
	// helpers
	// ********************
	task automatic end_of_test;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic rng(input string s, input int lo, input int hi, input int v);
		checks++;
		if (v < lo || v > hi)
		begin
			failures++;
			$display("ERROR %s expected %0d..%0d seen %0d", s, lo, hi, v);
		end
	endtask
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e)
		begin
			failures++;
			$display("ERROR %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic go_reset;
		rst <= 1'b1;
		want <= '0;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
	endtask
	task automatic av(input logic w, input logic [3:0] a, input logic [31:0] d);
		int k;
		k = 0;
		av_address <= a;
		av_writedata <= d;
		av_write <= w;
		av_read <= !w;
		@(posedge clk);
		while (av_waitrequest !== 1'b0)
		begin
			@(posedge clk);
			k++;
		end
		q = av_readdata;
		av_write <= 1'b0;
		av_read <= 1'b0;
		@(posedge clk);
		rng("waitrequest", 1, 1, k);
	endtask
	task automatic wt(input int b, input logic v, input int lim);
		n = 0;
		while (n < lim && outs[b] !== v)
		begin
			@(posedge clk);
			n++;
		end
	endtask
	// ********************
	// scenarios
	// ********************
	task automatic t_regs;
		go_reset();
		chk("outs", 32'h0, outs);
		av(1'b0, ctg_pkg::CFG_OFS, 32'h0);
		chk("cfg reset", 32'h0, q);
		av(1'b1, ctg_pkg::CFG_OFS, 32'hffff_ffff);
		av(1'b0, ctg_pkg::CFG_OFS, 32'h0);
		chk("cfg mask", 32'h01ff_ffff, q);
		av_byteenable <= 4'h2;
		av(1'b1, ctg_pkg::CFG_OFS, 32'h0);
		av_byteenable <= 4'hf;
		av(1'b0, ctg_pkg::CFG_OFS, 32'h0);
		chk("cfg lanes", 32'h01ff_00ff, q);
		av(1'b1, ctg_pkg::STATUS_OFS, 32'hffff_ffff);
		av(1'b0, ctg_pkg::STATUS_OFS, 32'h0);
		chk("status", 32'h0, q);
		av(1'b0, 4'h8, 32'h0);
		chk("unmapped", 32'h0, q);
	endtask
	task automatic t_pretrip;
		int s[4] = '{0, 1, 8, 15};
		for (int i = 0; i < 4; i++)
		begin
			go_reset();
			av(1'b1, 4'h0, s[i] | (i == 3 ? 32'h013f_e000 : 32'h0));
			want.trip <= 1'b1;
			wt(2, 1'b1, 400);
			rng("pretrip", 2 * s[i] * T - T, 2 * s[i] * T + 6, n);
		end
	endtask
	task automatic t_holds;
		for (int b = 1; b < 3; b++)
			for (int s = 0; s < 4; s++)
			begin
				go_reset();
				av(1'b1, 4'h0, s << (b == 2 ? 4 : 6));
				want <= (b == 2) ? 4'h8 : 4'h4;
				wt(b, 1'b1, 20);
				want <= '0;
				wt(b, 1'b0, 1200);
				rng("hold", hv[s] * T - T, hv[s] * T + 6, n);
			end
	endtask
	task automatic t_lowlevel;
		for (int s = 0; s < 4; s++)
		begin
			go_reset();
			av(1'b1, 4'h0, s << 22);
			want.lowlevel <= 1'b1;
			wt(0, 1'b1, 1200);
			rng("lowlevel", lv[s] * T - T, lv[s] * T + 6, n);
		end
	endtask
	task automatic t_unblock;
		for (int s = 0; s < 4; s++)
		begin
			go_reset();
			av(1'b1, 4'h0, 32'h0040_0000 | (s << 8));
			want.lowlevel <= 1'b1;
			wt(2, 1'b1, 800);
			if (s == 0)
				rng("no window", 800, 800, n);
			else
			begin
				rng("window start", 49 * T, 50 * T + 8, n);
				wt(2, 1'b0, 6000);
				rng("window len", uv[s] * T - T, uv[s] * T + 6, n);
			end
		end
	endtask
	task automatic t_noise;
		for (int b = 0; b < 2; b++)
		begin
			go_reset();
			av(1'b1, 4'h0, 32'h100 | (b << 10));
			want <= 4'h3;
			wt(2, 1'b1, 300);
			rng("noise", b ? 300 : 0, b ? 300 : 8, n);
			av(1'b0, ctg_pkg::STATUS_OFS, 32'h0);
			chk("noise status", b ? 32'h0000_0261 : 32'h0000_02e9, q);
		end
	endtask
	task automatic t_guard_first;
		go_reset();
		av(1'b1, 4'h0, 32'h800);
		want <= 4'h8;
		wt(2, 1'b1, 300);
		rng("no guard", 300, 300, n);
		want <= 4'h4;
		repeat (1100) @(posedge clk);
		want <= 4'h8;
		wt(2, 1'b1, 100);
		rng("short guard", 100, 100, n);
		want <= 4'h4;
		repeat (1250) @(posedge clk);
		want <= 4'h8;
		wt(2, 1'b1, 20);
		rng("armed", 0, 8, n);
		go_reset();
		av(1'b1, 4'h0, 32'h1800);
		want <= 4'h8;
		wt(2, 1'b1, 20);
		rng("code off", 0, 8, n);
		go_reset();
		av(1'b1, 4'h0, 32'h1000);
		want <= 4'h8;
		wt(2, 1'b1, 10500);
		rng("override", 999 * T, 1001 * T + 8, n);
		go_reset();
		av(1'b1, 4'h0, 32'h1000);
		want <= 4'h2;
		repeat (20) @(posedge clk);
		want <= 4'h8;
		wt(2, 1'b1, 30);
		rng("loss waiver", 0, 8, n);
	endtask
	// ********************
	// clock, watchdog, sequence
	// ********************
	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	initial
	begin
		repeat (60000) @(posedge clk);
		failures++;
		$display("ERROR watchdog expected done seen running");
		end_of_test();
	end
	initial
	begin
		{av_read, av_write} = 2'h0;
		{av_address, av_byteenable, av_writedata} = {4'h0, 4'hf, 32'h0};
		failures = 0;
		checks = 0;
		t_regs();
		t_pretrip();
		t_holds();
		t_lowlevel();
		t_unblock();
		t_noise();
		t_guard_first();
		end_of_test();
	end
endmodule // tb_top
`default_nettype wire
